// >>> gprb_pkg.sv
// Register map, field layout and carrier types of the pipeline register bank.
// Assumes offsets are byte offsets from the processor register base.
package gprb_pkg;

    // ------------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------------
    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;
    localparam int BE_W = 4;
    localparam int NREG = 12;
    localparam int PAT_WORDS = 4;

    // ------------------------------------------------------------------
    // Byte offsets
    // ------------------------------------------------------------------
    localparam logic [15:0] OFS_PAT0 = 16'h8120;
    localparam logic [15:0] OFS_PAT1 = 16'h8124;
    localparam logic [15:0] OFS_PAT2 = 16'h8128;
    localparam logic [15:0] OFS_PAT3 = 16'h812c;
    localparam logic [15:0] OFS_VGA_WR = 16'h8140;
    localparam logic [15:0] OFS_VGA_RD = 16'h8144;
    localparam logic [15:0] OFS_RASTER = 16'h8200;
    localparam logic [15:0] OFS_VECTOR = 16'h8204;
    localparam logic [15:0] OFS_BLT = 16'h8208;
    localparam logic [15:0] OFS_STATUS = 16'h820c;
    localparam logic [15:0] OFS_VGA_BASE = 16'h8210;
    localparam logic [15:0] OFS_LATCH = 16'h8214;

    // ------------------------------------------------------------------
    // Storage indices
    // ------------------------------------------------------------------
    localparam logic [3:0] IDX_PAT0 = 4'h0;
    localparam logic [3:0] IDX_PAT1 = 4'h1;
    localparam logic [3:0] IDX_PAT2 = 4'h2;
    localparam logic [3:0] IDX_PAT3 = 4'h3;
    localparam logic [3:0] IDX_VGA_WR = 4'h4;
    localparam logic [3:0] IDX_VGA_RD = 4'h5;
    localparam logic [3:0] IDX_RASTER = 4'h6;
    localparam logic [3:0] IDX_VECTOR = 4'h7;
    localparam logic [3:0] IDX_BLT = 4'h8;
    localparam logic [3:0] IDX_STATUS = 4'h9;
    localparam logic [3:0] IDX_VGA_BASE = 4'ha;
    localparam logic [3:0] IDX_LATCH = 4'hb;

    // ------------------------------------------------------------------
    // Reset values and field masks
    // ------------------------------------------------------------------
    localparam logic [31:0] RST_VAL = 32'h0000_0000;
    localparam logic [31:0] RST_VGA_RD = 32'h0000_0000;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
    // Status byte is engine-owned; only the upper three bytes store config
    localparam logic [3:0] STATUS_BE_MASK = 4'he;
    localparam int STATUS_BITS = 8;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic we;
        logic [15:0] addr;
        logic [31:0] wdata;
        logic [3:0] be;
    } gprb_req_t;

    typedef struct packed {
        logic [127:0] pattern;
        logic [31:0] raster_mode;
        logic [31:0] vector_mode;
        logic [31:0] blt_mode;
        logic [31:0] blt_config;
        logic [31:0] vga_write_ctrl;
        logic [31:0] vga_read_ctrl;
        logic [31:0] vga_mem_base;
        logic [31:0] vga_latch;
    } gprb_cfg_t;

endpackage : gprb_pkg

// >>> gprb_top.sv
// Upper half of the 2D pipeline configuration register bank.
// Assumes one request per cycle on the register port, same clock as the engine.
//
// Contract
// RQ1 - Four pattern words form one 128-bit pattern
// RQ2 - Word n supplies pattern bits 32n+31 to 32n
// RQ3 - Vector mode write starts a vector
// RQ4 - Block-transfer mode write starts a transfer
// RQ5 - Status held in low byte, config above
// RQ6 - Raster mode selects per-pixel raster operation
// RQ7 - Legacy memory base offsets emulated accesses
// RQ8 - Display latch readable and writable by software
// RQ9 - Write path control configures legacy writes
// RQ10 - Read path control configures reads, resets zero
// RQ11 - Software loads operands before launching
`timescale 1ns/1ps
module gprb_top (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Register port
    input wire logic req_valid,
    input wire gprb_pkg::gprb_req_t req,
    output logic rsp_valid,
    output logic [31:0] rsp_rdata,
    // Engine side
    input wire logic [7:0] engine_status,
    input wire logic latch_load,
    input wire logic [31:0] latch_load_data,
    output logic line_draw_start,
    output logic block_transfer_start,
    output gprb_pkg::gprb_cfg_t cfg
);

    // ------------------------------------------------------------------
    // Decode and merge helpers
    // ------------------------------------------------------------------
    function automatic logic [4:0] decode(input logic [15:0] a);
        logic [4:0] r;
        r = {1'b1, gprb_pkg::IDX_PAT0};
        case (a)
            gprb_pkg::OFS_PAT0: r = {1'b1, gprb_pkg::IDX_PAT0};
            gprb_pkg::OFS_PAT1: r = {1'b1, gprb_pkg::IDX_PAT1};
            gprb_pkg::OFS_PAT2: r = {1'b1, gprb_pkg::IDX_PAT2};
            gprb_pkg::OFS_PAT3: r = {1'b1, gprb_pkg::IDX_PAT3};
            gprb_pkg::OFS_VGA_WR: r = {1'b1, gprb_pkg::IDX_VGA_WR};
            gprb_pkg::OFS_VGA_RD: r = {1'b1, gprb_pkg::IDX_VGA_RD};
            gprb_pkg::OFS_RASTER: r = {1'b1, gprb_pkg::IDX_RASTER};
            gprb_pkg::OFS_VECTOR: r = {1'b1, gprb_pkg::IDX_VECTOR};
            gprb_pkg::OFS_BLT: r = {1'b1, gprb_pkg::IDX_BLT};
            gprb_pkg::OFS_STATUS: r = {1'b1, gprb_pkg::IDX_STATUS};
            gprb_pkg::OFS_VGA_BASE: r = {1'b1, gprb_pkg::IDX_VGA_BASE};
            gprb_pkg::OFS_LATCH: r = {1'b1, gprb_pkg::IDX_LATCH};
            default: r = {1'b0, gprb_pkg::IDX_PAT0};
        endcase
        return r;
    endfunction : decode

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < gprb_pkg::BE_W; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    // ------------------------------------------------------------------
    // Request decode
    // ------------------------------------------------------------------
    logic [4:0] dec;
    logic hit;
    logic [3:0] idx;
    logic wr_en;
    logic rd_en;

    assign dec = decode(req.addr);
    assign hit = dec[4];
    assign idx = dec[3:0];
    assign wr_en = req_valid & req.we & hit;
    assign rd_en = req_valid & ~req.we;

    // ------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------
    logic [31:0] regs_q [gprb_pkg::NREG];
    logic [31:0] regs_d [gprb_pkg::NREG];
    logic line_start_q;
    logic line_start_d;
    logic blt_start_q;
    logic blt_start_d;
    logic rsp_valid_q;
    logic rsp_valid_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [3:0] be_eff;
    logic [31:0] rd_word;

    always_comb begin
        for (int i = 0; i < gprb_pkg::NREG; i++) begin
            regs_d[i] = regs_q[i];
        end
        // Engine byte of the status word cannot be overwritten
        be_eff = (idx == gprb_pkg::IDX_STATUS) ? (req.be & gprb_pkg::STATUS_BE_MASK) : req.be; // RQ5
        // Software bytes win over a same-cycle latch load; unwritten bytes keep the load
        if (latch_load) begin
            regs_d[gprb_pkg::IDX_LATCH] = latch_load_data; // RQ8
        end
        if (wr_en) begin
            regs_d[idx] = merge(regs_d[idx], req.wdata, be_eff); // RQ8 RQ9 RQ10
        end
        // Launch is a pulse in the cycle the new mode word becomes visible
        line_start_d = wr_en & (idx == gprb_pkg::IDX_VECTOR); // RQ3
        blt_start_d = wr_en & (idx == gprb_pkg::IDX_BLT); // RQ4
        if (idx == gprb_pkg::IDX_STATUS) begin
            rd_word = {regs_q[idx][31:gprb_pkg::STATUS_BITS], engine_status}; // RQ5
        end else begin
            rd_word = regs_q[idx]; // RQ8
        end
        rsp_valid_d = rd_en;
        // Unmapped reads return zero so software never sees stale data
        rdata_d = (rd_en & hit) ? rd_word : gprb_pkg::ZERO_WORD;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            for (int i = 0; i < gprb_pkg::NREG; i++) begin
                regs_q[i] <= gprb_pkg::RST_VAL;
            end
            regs_q[gprb_pkg::IDX_VGA_RD] <= gprb_pkg::RST_VGA_RD; // RQ10
            line_start_q <= 1'b0;
            blt_start_q <= 1'b0;
            rsp_valid_q <= 1'b0;
            rdata_q <= gprb_pkg::ZERO_WORD;
        end else begin
            for (int i = 0; i < gprb_pkg::NREG; i++) begin
                regs_q[i] <= regs_d[i];
            end
            line_start_q <= line_start_d;
            blt_start_q <= blt_start_d;
            rsp_valid_q <= rsp_valid_d;
            rdata_q <= rdata_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign rsp_valid = rsp_valid_q;
    assign rsp_rdata = rdata_q;
    assign line_draw_start = line_start_q; // RQ3
    assign block_transfer_start = blt_start_q; // RQ4
    assign cfg.pattern = {regs_q[gprb_pkg::IDX_PAT3], regs_q[gprb_pkg::IDX_PAT2],
                          regs_q[gprb_pkg::IDX_PAT1], regs_q[gprb_pkg::IDX_PAT0]}; // RQ1 RQ2
    assign cfg.raster_mode = regs_q[gprb_pkg::IDX_RASTER]; // RQ6
    assign cfg.vector_mode = regs_q[gprb_pkg::IDX_VECTOR];
    assign cfg.blt_mode = regs_q[gprb_pkg::IDX_BLT];
    assign cfg.blt_config = {regs_q[gprb_pkg::IDX_STATUS][31:gprb_pkg::STATUS_BITS],
                             {gprb_pkg::STATUS_BITS{1'b0}}}; // RQ5
    assign cfg.vga_write_ctrl = regs_q[gprb_pkg::IDX_VGA_WR]; // RQ9
    assign cfg.vga_read_ctrl = regs_q[gprb_pkg::IDX_VGA_RD]; // RQ10
    assign cfg.vga_mem_base = regs_q[gprb_pkg::IDX_VGA_BASE]; // RQ7
    assign cfg.vga_latch = regs_q[gprb_pkg::IDX_LATCH]; // RQ8

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    logic full_wr;
    assign full_wr = req_valid & req.we & (req.be == 4'hf);

    property p_pattern_assembly;
        @(posedge sys_clk) disable iff (rst)
        (full_wr && req.addr == gprb_pkg::OFS_PAT0) ##1 (full_wr && req.addr == gprb_pkg::OFS_PAT1)
        ##1 (full_wr && req.addr == gprb_pkg::OFS_PAT2) ##1 (full_wr && req.addr == gprb_pkg::OFS_PAT3)
        |=> cfg.pattern == {$past(req.wdata, 1), $past(req.wdata, 2), $past(req.wdata, 3),
                            $past(req.wdata, 4)};
    endproperty
    a_pattern_assembly: assert property (p_pattern_assembly) else $error("pattern not assembled"); // RQ1

    property p_pattern_word2;
        @(posedge sys_clk) disable iff (rst)
        (full_wr && req.addr == gprb_pkg::OFS_PAT2) |=> cfg.pattern[95:64] == $past(req.wdata)
        && $stable(cfg.pattern[63:0]);
    endproperty
    a_pattern_word2: assert property (p_pattern_word2) else $error("pattern word 2 misplaced"); // RQ2

    property p_vector_launch;
        @(posedge sys_clk) disable iff (rst)
        (req_valid && req.we && req.addr == gprb_pkg::OFS_VECTOR) |=> line_draw_start
        ##1 (!line_draw_start || $past(req_valid && req.we && req.addr == gprb_pkg::OFS_VECTOR));
    endproperty
    a_vector_launch: assert property (p_vector_launch) else $error("vector launch wrong"); // RQ3

    property p_blt_cause;
        @(posedge sys_clk) disable iff (rst)
        $rose(block_transfer_start) |-> $past(req_valid && req.we && req.addr == gprb_pkg::OFS_BLT)
        && !line_draw_start;
    endproperty
    a_blt_cause: assert property (p_blt_cause) else $error("transfer launch without write"); // RQ4

    property p_status_byte;
        @(posedge sys_clk) disable iff (rst)
        (req_valid && !req.we && req.addr == gprb_pkg::OFS_STATUS) |=>
        rsp_valid && rsp_rdata[7:0] == $past(engine_status) && cfg.blt_config[7:0] == 8'h00;
    endproperty
    a_status_byte: assert property (p_status_byte) else $error("status byte wrong"); // RQ5

    property p_raster_write;
        @(posedge sys_clk) disable iff (rst)
        (full_wr && req.addr == gprb_pkg::OFS_RASTER) |=> cfg.raster_mode == $past(req.wdata);
    endproperty
    a_raster_write: assert property (p_raster_write) else $error("raster mode not stored"); // RQ6

    property p_base_write;
        @(posedge sys_clk) disable iff (rst)
        (full_wr && req.addr == gprb_pkg::OFS_VGA_BASE) |=> cfg.vga_mem_base == $past(req.wdata);
    endproperty
    a_base_write: assert property (p_base_write) else $error("memory base not stored"); // RQ7

    property p_latch_read;
        @(posedge sys_clk) disable iff (rst)
        (req_valid && !req.we && req.addr == gprb_pkg::OFS_LATCH) |=>
        rsp_rdata == $past(cfg.vga_latch);
    endproperty
    a_latch_read: assert property (p_latch_read) else $error("latch read mismatch"); // RQ8

    property p_write_ctrl;
        @(posedge sys_clk) disable iff (rst)
        (full_wr && req.addr == gprb_pkg::OFS_VGA_WR) |=> cfg.vga_write_ctrl == $past(req.wdata);
    endproperty
    a_write_ctrl: assert property (p_write_ctrl) else $error("write path control lost"); // RQ9

    property p_read_ctrl_reset;
        @(posedge sys_clk) $past(rst) && !rst |-> cfg.vga_read_ctrl == 32'h0000_0000;
    endproperty
    a_read_ctrl_reset: assert property (p_read_ctrl_reset) else $error("read control not zero"); // RQ10

    property p_unmapped_zero;
        @(posedge sys_clk) disable iff (rst)
        (req_valid && !req.we && !hit) |=> rsp_valid && rsp_rdata == 32'h0000_0000;
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");

    property p_cov_vec;
        @(posedge sys_clk) disable iff (rst) line_draw_start;
    endproperty
    c_cov_vec: cover property (p_cov_vec);

    property p_cov_blt_after_pat;
        @(posedge sys_clk) disable iff (rst)
        (full_wr && req.addr == gprb_pkg::OFS_PAT3) ##[1:20] block_transfer_start;
    endproperty
    c_cov_blt_after_pat: cover property (p_cov_blt_after_pat);

    property p_cov_latch_clash;
        @(posedge sys_clk) disable iff (rst) latch_load && wr_en && idx == gprb_pkg::IDX_LATCH;
    endproperty
    c_cov_latch_clash: cover property (p_cov_latch_clash);

endmodule : gprb_top

// >>> gprb_tb.sv
// Self-checking bench for the pipeline register bank: mirror model plus read queue.
// Assumes the register port is driven alone, one request per cycle, no ready.
`timescale 1ns/1ps
module tb;
    // ------------------------------------------------------------------
    // Signals and model state
    // ------------------------------------------------------------------
    localparam logic [15:0] OFS [12] = '{gprb_pkg::OFS_PAT0, gprb_pkg::OFS_PAT1,
        gprb_pkg::OFS_PAT2, gprb_pkg::OFS_PAT3, gprb_pkg::OFS_VGA_WR, gprb_pkg::OFS_VGA_RD,
        gprb_pkg::OFS_RASTER, gprb_pkg::OFS_VECTOR, gprb_pkg::OFS_BLT, gprb_pkg::OFS_STATUS,
        gprb_pkg::OFS_VGA_BASE, gprb_pkg::OFS_LATCH};
    logic sys_clk, rst, req_valid, latch_load, rsp_valid, line_draw_start, block_transfer_start;
    gprb_pkg::gprb_req_t req;
    logic [7:0] engine_status, es_v;
    logic [31:0] latch_load_data, rsp_rdata, r, mir [12];
    gprb_pkg::gprb_cfg_t cfg;
    logic [31:0] exp_q [$];
    logic [31:0] seed;
    int err_total, checks_done, exp_line, exp_blt, got_line, got_blt;

    gprb_top dut_u (.sys_clk(sys_clk), .rst(rst), .req_valid(req_valid), .req(req),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .engine_status(engine_status),
        .latch_load(latch_load), .latch_load_data(latch_load_data),
        .line_draw_start(line_draw_start), .block_transfer_start(block_transfer_start),
        .cfg(cfg));

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    task automatic chk(input logic [383:0] got, input logic [383:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // Expectation is taken before driving but after the mirror latch load, so it sees no other effect of this request
    task automatic xfer(input logic we, input logic [15:0] a, input logic [31:0] d,
                        input logic [3:0] be, input logic ld, input logic [31:0] ldd);
        int idx;
        idx = -1;
        for (int i = 0; i < 12; i++) if (OFS[i] == a) idx = i;
        if (ld) mir[11] = ldd;
        if (we && idx >= 0) begin
            for (int b = 0; b < 4; b++) begin
                if (be[b] && !(idx == 9 && b == 0)) mir[idx][8*b+:8] = d[8*b+:8];
            end
            if (idx == 7) exp_line++;
            if (idx == 8) exp_blt++;
        end
        if (!we) exp_q.push_back(idx < 0 ? 32'h0 : idx == 9 ? {mir[9][31:8], es_v} : mir[idx]);
        @(posedge sys_clk);
        req_valid <= 1'b1;
        req <= '{we: we, addr: a, wdata: d, be: be};
        latch_load <= ld;
        latch_load_data <= ldd;
    endtask : xfer

    task automatic idle_check();
        gprb_pkg::gprb_cfg_t e;
        @(posedge sys_clk);
        req_valid <= 1'b0;
        latch_load <= 1'b0;
        repeat (2) @(negedge sys_clk);
        e = '{pattern: {mir[3], mir[2], mir[1], mir[0]}, raster_mode: mir[6],
              vector_mode: mir[7], blt_mode: mir[8], blt_config: mir[9],
              vga_write_ctrl: mir[4], vga_read_ctrl: mir[5], vga_mem_base: mir[10],
              vga_latch: mir[11]};
        chk(cfg, e);
        chk(384'(got_line), 384'(exp_line));
        chk(384'(got_blt), 384'(exp_blt));
        chk(384'(exp_q.size()), 384'h0);
    endtask : idle_check

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : report_and_stop

    // ------------------------------------------------------------------
    // Output watcher
    // ------------------------------------------------------------------
    always @(negedge sys_clk) begin
        if (line_draw_start === 1'b1) got_line++;
        if (block_transfer_start === 1'b1) got_blt++;
        if (rsp_valid === 1'b1) begin
            if (exp_q.size() == 0) chk(384'(rsp_rdata), 384'hdead);
            else chk(384'(rsp_rdata), 384'(exp_q.pop_front()));
        end
    end

    // Whole run is about a hundred cycles; this limit only catches a hang
    initial begin
        #200000;
        err_total++;
        report_and_stop();
    end

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        rst = 1'b1;
        req_valid = 1'b0;
        req = '0;
        latch_load = 1'b0;
        latch_load_data = 32'h0;
        engine_status = 8'h00;
        es_v = 8'h00;
        seed = 32'h6;
        err_total = 0;
        checks_done = 0;
        exp_line = 0;
        exp_blt = 0;
        got_line = 0;
        got_blt = 0;
        for (int i = 0; i < 12; i++) mir[i] = 32'h0;
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        for (int i = 0; i < 12; i++) xfer(1'b0, OFS[i], 32'h0, 4'h0, 1'b0, 32'h0);
        xfer(1'b1, 16'h8130, 32'hffffffff, 4'hf, 1'b0, 32'h0);
        xfer(1'b0, 16'h8130, 32'h0, 4'h0, 1'b0, 32'h0);
        idle_check();
        $display("test reset and unmapped done");
        for (int i = 0; i < 4; i++) xfer(1'b1, OFS[i], rnd(), 4'hf, 1'b0, 32'h0);
        xfer(1'b1, OFS[1], rnd(), 4'h5, 1'b0, 32'h0);
        for (int i = 0; i < 4; i++) xfer(1'b0, OFS[i], 32'h0, 4'h0, 1'b0, 32'h0);
        idle_check();
        $display("test pattern done");
        xfer(1'b1, OFS[6], rnd(), 4'hf, 1'b0, 32'h0);
        xfer(1'b1, OFS[7], rnd(), 4'hf, 1'b0, 32'h0);
        xfer(1'b1, OFS[8], rnd(), 4'hf, 1'b0, 32'h0);
        xfer(1'b1, OFS[7], rnd(), 4'h2, 1'b0, 32'h0);
        xfer(1'b1, OFS[8], rnd(), 4'h8, 1'b0, 32'h0);
        xfer(1'b0, OFS[6], 32'h0, 4'h0, 1'b0, 32'h0);
        idle_check();
        $display("test launch done");
        r = rnd();
        es_v = r[7:0];
        @(posedge sys_clk);
        engine_status <= r[7:0];
        xfer(1'b1, OFS[9], 32'hffffffff, 4'hf, 1'b0, 32'h0);
        xfer(1'b0, OFS[9], 32'h0, 4'h0, 1'b0, 32'h0);
        idle_check();
        $display("test status done");
        xfer(1'b1, OFS[11], rnd(), 4'h0, 1'b1, rnd());
        xfer(1'b0, OFS[11], 32'h0, 4'h0, 1'b0, 32'h0);
        xfer(1'b1, OFS[11], rnd(), 4'h3, 1'b1, rnd());
        xfer(1'b0, OFS[11], 32'h0, 4'h0, 1'b0, 32'h0);
        idle_check();
        $display("test latch done");
        for (int k = 0; k < 40; k++) begin
            r = rnd();
            xfer(r[0], OFS[r[7:4] % 12], rnd(), r[11:8], 1'b0, 32'h0);
        end
        idle_check();
        $display("test random traffic done");
        report_and_stop();
    end
endmodule : tb
